// ==== design/psd_consts.svh ====
// Field positions, widths and defaults of the power state descriptor low half
`ifndef PSD_CONSTS_SVH
`define PSD_CONSTS_SVH

`define PSD_WORD_W 128
`define PSD_RANK_W 5
`define PSD_TIME_W 32
`define PSD_POWER_W 16
`define PSD_WORD_BITS 32

`define PSD_WORD0_LSB 0
`define PSD_WORD1_LSB 32
`define PSD_WORD2_LSB 64
`define PSD_WORD3_LSB 96

`define PSD_WLAT_LSB 120
`define PSD_WTHR_LSB 112
`define PSD_RLAT_LSB 104
`define PSD_RTHR_LSB 96
`define PSD_LEAVE_LSB 64
`define PSD_ENTER_LSB 32
`define PSD_HALT_BIT 25
`define PSD_UNIT_BIT 24
`define PSD_POWER_LSB 0

`define PSD_NUM_STATES 5'h10

`define PSD_RANK_RST 5'h00
`define PSD_TIME_RST 32'h0000_0000
`define PSD_FLAG_RST 1'b0
`define PSD_POWER_RST 16'h0000
`define PSD_RDATA_IDLE 32'h0000_0000

`define PSD_ADDR_W 3
`define PSD_ADDR_WORD0 3'h0
`define PSD_ADDR_WORD1 3'h1
`define PSD_ADDR_WORD2 3'h2
`define PSD_ADDR_WORD3 3'h3
`define PSD_ADDR_CTRL 3'h4
`define PSD_ADDR_STAT 3'h5

`endif

// ==== design/psd_pkg.sv ====
// Types shared by the power state descriptor block
package psd_pkg;
   typedef logic [4:0] psd_rank_t;
   typedef logic [31:0] psd_word_t;
   typedef enum logic [1:0] {
      PSD_UNIT_CENTIWATT = 2'b01,
      PSD_UNIT_DECIMILLIWATT = 2'b10
   } psd_unit_e;
endpackage

// ==== design/psd_fields.sv ====
// Power state descriptor low 128 bits: field store, encoder and checker
`include "psd_consts.svh"

module psd_fields #(
   parameter logic [4:0] NUM_STATES = `PSD_NUM_STATES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [`PSD_ADDR_W-1:0] addr_i,
   input wire psd_pkg::psd_word_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output psd_pkg::psd_word_t rdata_o,
   output logic [`PSD_WORD_W-1:0] descriptor_o,
   output logic ranks_valid_o
);
   import psd_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // A rank at or above the state count is meaningless to the host
   function automatic logic rank_ok(input psd_rank_t r);
      rank_ok = (r < NUM_STATES);
   endfunction

   // A strobe and an index pick one descriptor word; indices 4 to 7 pick none
   function automatic logic word_hit(
      input logic strobe,
      input logic [`PSD_ADDR_W-1:0] index,
      input logic [`PSD_ADDR_W-1:0] target
   );
      word_hit = strobe && (index == target);
   endfunction

   // Rank positions are descriptor bits, rebased here onto the top word
   function automatic psd_rank_t rank_field(
      input psd_word_t word,
      input int unsigned lsb
   );
      rank_field = word[lsb - `PSD_WORD3_LSB +: `PSD_RANK_W];
   endfunction

   // Only the peak power bits are kept from the low half of the bottom word
   function automatic logic [`PSD_POWER_W-1:0] power_field(input psd_word_t word);
      power_field = word[`PSD_POWER_LSB +: `PSD_POWER_W];
   endfunction

   // Top word: four ranks, reserved ranges clear
   function automatic psd_word_t pack_rank_word(
      input psd_rank_t wr_lat,
      input psd_rank_t wr_thr,
      input psd_rank_t rd_lat,
      input psd_rank_t rd_thr
   );
      psd_word_t word;
      word = '0;
      word[`PSD_WLAT_LSB - `PSD_WORD3_LSB +: `PSD_RANK_W] = wr_lat;
      word[`PSD_WTHR_LSB - `PSD_WORD3_LSB +: `PSD_RANK_W] = wr_thr;
      word[`PSD_RLAT_LSB - `PSD_WORD3_LSB +: `PSD_RANK_W] = rd_lat;
      word[`PSD_RTHR_LSB - `PSD_WORD3_LSB +: `PSD_RANK_W] = rd_thr;
      pack_rank_word = word;
   endfunction

   // Bottom word: halt flag, unit select and peak power, reserved ranges clear
   function automatic psd_word_t pack_power_word(
      input logic halted,
      input logic unit_sel,
      input logic [`PSD_POWER_W-1:0] power
   );
      psd_word_t word;
      word = '0;
      word[`PSD_HALT_BIT] = halted;
      word[`PSD_UNIT_BIT] = unit_sel;
      word[`PSD_POWER_LSB +: `PSD_POWER_W] = power;
      pack_power_word = word;
   endfunction

   // Indices 4 and 5 are read-only views; 6 and 7 read zero
   function automatic psd_word_t read_word(
      input logic [`PSD_ADDR_W-1:0] index,
      input logic [`PSD_WORD_W-1:0] desc,
      input logic valid
   );
      unique case (index)
         `PSD_ADDR_WORD0: begin
            read_word = desc[`PSD_WORD0_LSB +: `PSD_WORD_BITS];
         end
         `PSD_ADDR_WORD1: begin
            read_word = desc[`PSD_WORD1_LSB +: `PSD_WORD_BITS];
         end
         `PSD_ADDR_WORD2: begin
            read_word = desc[`PSD_WORD2_LSB +: `PSD_WORD_BITS];
         end
         `PSD_ADDR_WORD3: begin
            read_word = desc[`PSD_WORD3_LSB +: `PSD_WORD_BITS];
         end
         `PSD_ADDR_CTRL: begin
            read_word = psd_word_t'(NUM_STATES);
         end
         `PSD_ADDR_STAT: begin
            read_word = psd_word_t'(valid);
         end
         default: begin
            read_word = `PSD_RDATA_IDLE;
         end
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Field store
   // ----------------------------------------------------------------
   psd_rank_t read_throughput_rank;
   psd_rank_t read_latency_rank;
   psd_rank_t write_throughput_rank;
   psd_rank_t write_latency_rank;
   logic [`PSD_TIME_W-1:0] state_leave_time_us;
   logic [`PSD_TIME_W-1:0] state_enter_time_us;
   logic io_halted_flag;
   logic peak_power_unit_select;
   logic [`PSD_POWER_W-1:0] peak_power_value;

   // Registered so read data stand for exactly one cycle
   psd_word_t rdata;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   logic hit_word0;
   logic hit_word1;
   logic hit_word2;
   logic hit_word3;

   // Writes to 4 to 7 match no word and are dropped
   assign hit_word0 = word_hit(wr_i, addr_i, `PSD_ADDR_WORD0);
   assign hit_word1 = word_hit(wr_i, addr_i, `PSD_ADDR_WORD1);
   assign hit_word2 = word_hit(wr_i, addr_i, `PSD_ADDR_WORD2);
   assign hit_word3 = word_hit(wr_i, addr_i, `PSD_ADDR_WORD3);

   // ----------------------------------------------------------------
   // Rank fields
   // ----------------------------------------------------------------
   // Out-of-range ranks are stored as written and flagged by the checker
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_throughput_rank <= `PSD_RANK_RST;
      end else if (hit_word3) begin
         read_throughput_rank <= rank_field(wdata_i, `PSD_RTHR_LSB);
      end
   end

   // Smaller rank means shorter read latency
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_latency_rank <= `PSD_RANK_RST;
      end else if (hit_word3) begin
         read_latency_rank <= rank_field(wdata_i, `PSD_RLAT_LSB);
      end
   end

   // Smaller rank means higher write throughput
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         write_throughput_rank <= `PSD_RANK_RST;
      end else if (hit_word3) begin
         write_throughput_rank <= rank_field(wdata_i, `PSD_WTHR_LSB);
      end
   end

   // Smaller rank means shorter write latency
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         write_latency_rank <= `PSD_RANK_RST;
      end else if (hit_word3) begin
         write_latency_rank <= rank_field(wdata_i, `PSD_WLAT_LSB);
      end
   end

   // ----------------------------------------------------------------
   // Latency fields
   // ----------------------------------------------------------------
   // Zero is legal here: it tells the host the time is not reported
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_leave_time_us <= `PSD_TIME_RST;
      end else if (hit_word2) begin
         state_leave_time_us <= wdata_i;
      end
   end

   // Whole word is the time, so nothing is dropped on write
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_enter_time_us <= `PSD_TIME_RST;
      end else if (hit_word1) begin
         state_enter_time_us <= wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // Power word fields
   // ----------------------------------------------------------------
   // Flag, unit and value share one write, so the host never sees a mixed word
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         io_halted_flag <= `PSD_FLAG_RST;
      end else if (hit_word0) begin
         io_halted_flag <= wdata_i[`PSD_HALT_BIT];
      end
   end

   // Low selects the coarse unit, high the fine one
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         peak_power_unit_select <= `PSD_FLAG_RST;
      end else if (hit_word0) begin
         peak_power_unit_select <= wdata_i[`PSD_UNIT_BIT];
      end
   end

   // Zero is stored like any value; it reads as not reported
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         peak_power_value <= `PSD_POWER_RST;
      end else if (hit_word0) begin
         peak_power_value <= power_field(wdata_i);
      end
   end

   // ----------------------------------------------------------------
   // Checker
   // ----------------------------------------------------------------
   logic read_throughput_ok;
   logic read_latency_ok;
   logic write_throughput_ok;
   logic write_latency_ok;

   // One compare per rank against the state count parameter
   assign read_throughput_ok = rank_ok(read_throughput_rank);
   assign read_latency_ok = rank_ok(read_latency_rank);
   assign write_throughput_ok = rank_ok(write_throughput_rank);
   assign write_latency_ok = rank_ok(write_latency_rank);

   // Software must not publish a descriptor while this is low
   assign ranks_valid_o = read_throughput_ok
                          && read_latency_ok
                          && write_throughput_ok
                          && write_latency_ok;

   // ----------------------------------------------------------------
   // Descriptor words
   // ----------------------------------------------------------------
   psd_word_t rank_word;
   psd_word_t power_word;

   // Packed from zero so the reserved ranges inside each word stay clear
   assign rank_word = pack_rank_word(
      write_latency_rank,
      write_throughput_rank,
      read_latency_rank,
      read_throughput_rank
   );
   assign power_word = pack_power_word(
      io_halted_flag,
      peak_power_unit_select,
      peak_power_value
   );

   // ----------------------------------------------------------------
   // Encoder
   // ----------------------------------------------------------------
   // Built from zero so every unused range stays clear
   always_comb begin
      descriptor_o = '0;
      descriptor_o[`PSD_WORD3_LSB +: `PSD_WORD_BITS] = rank_word;
      descriptor_o[`PSD_LEAVE_LSB +: `PSD_TIME_W] = state_leave_time_us;
      descriptor_o[`PSD_ENTER_LSB +: `PSD_TIME_W] = state_enter_time_us;
      descriptor_o[`PSD_WORD0_LSB +: `PSD_WORD_BITS] = power_word;
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   // Read data fall back to zero, so a stale word is never seen twice
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata <= `PSD_RDATA_IDLE;
      end else if (rd_i) begin
         rdata <= read_word(addr_i, descriptor_o, ranks_valid_o);
      end else begin
         rdata <= `PSD_RDATA_IDLE;
      end
   end

   assign rdata_o = rdata;
endmodule

// ==== bench/psd_fields_properties.sv ====
// Port checker for the descriptor field block
module psd_fields_properties #(parameter logic [4:0] NUM_STATES = 5'h10) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic ranks_valid_o,
   input wire logic [2:0] addr_i,
   input wire psd_pkg::psd_word_t wdata_i,
   input wire psd_pkg::psd_word_t rdata_o,
   input wire logic [127:0] descriptor_o);
   timeunit 1ns / 1ps;
   localparam logic [127:0] KEEP = 128'h1f1f1f1f_ffffffff_ffffffff_0300ffff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_w0; wr_i && addr_i == 3'h0; endsequence
   property p_rk; ranks_valid_o == (descriptor_o[100:96] < NUM_STATES && descriptor_o[108:104] < NUM_STATES
      && descriptor_o[116:112] < NUM_STATES && descriptor_o[124:120] < NUM_STATES); endproperty
   a_rk: assert property (p_rk) else $error("rank flag");
   property p_lv; wr_i && addr_i == 3'h2 |=> descriptor_o[95:64] == $past(wdata_i); endproperty
   a_lv: assert property (p_lv) else $error("leave time");
   property p_en; wr_i && addr_i == 3'h1 |=> descriptor_o[63:32] == $past(wdata_i); endproperty
   a_en: assert property (p_en) else $error("enter time");
   property p_ha; s_w0 |=> descriptor_o[25] == $past(wdata_i[25]); endproperty
   a_ha: assert property (p_ha) else $error("halt flag");
   property p_un; s_w0 |=> descriptor_o[24] == $past(wdata_i[24]); endproperty
   a_un: assert property (p_un) else $error("unit select");
   property p_pw; s_w0 |=> descriptor_o[15:0] == $past(wdata_i[15:0]); endproperty
   a_pw: assert property (p_pw) else $error("peak power");
   property p_rs; (descriptor_o & ~KEEP) == '0; endproperty
   a_rs: assert property (p_rs) else $error("reserved bits");
   property p_rd; rd_i && addr_i == 3'h3 |=> rdata_o == descriptor_o[127:96]; endproperty
   a_rd: assert property (p_rd) else $error("rank readback");
   property p_ct; rd_i && addr_i == 3'h4 |=> rdata_o == 32'(NUM_STATES); endproperty
   a_ct: assert property (p_ct) else $error("state count readback");
   property p_st; rd_i && addr_i == 3'h5 |=> rdata_o == 32'($past(ranks_valid_o)); endproperty
   a_st: assert property (p_st) else $error("rank flag readback");
endmodule

// ==== bench/psd_host.sv ====
// Host model: one register access at a time
module psd_host (
   input wire logic clk_i,
   input wire psd_pkg::psd_word_t rdata_i,
   output logic [2:0] addr_o,
   output psd_pkg::psd_word_t wdata_o,
   output logic wr_o,
   output logic rd_o);
   timeunit 1ns / 1ps;
   initial {addr_o, wdata_o, wr_o, rd_o} = '0;
   task automatic xfer(input logic w, input logic [2:0] a, input psd_pkg::psd_word_t d, output psd_pkg::psd_word_t q);
      @(posedge clk_i);
      {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
      @(posedge clk_i);
      {wr_o, rd_o} <= 2'h0;
      // Read data stand only until the next rising edge, so take them mid-cycle
      @(negedge clk_i);
      q = rdata_i;
   endtask
endmodule

// ==== bench/psd_fields_test.sv ====
// Self-checking bench for the descriptor field block
module psd_fields_test;
   timeunit 1ns / 1ps;
   localparam logic [127:0] KEEP = 128'h1f1f1f1f_ffffffff_ffffffff_0300ffff;
   logic clk_i = 1'b0, rst_i = 1'b1, wr_i, rd_i, ranks_valid_o;
   logic [2:0] addr_i;
   psd_pkg::psd_word_t wdata_i, rdata_o, q;
   logic [127:0] descriptor_o, w;
   int bad_count = 0, n_compared = 0;
   psd_host u_host (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
   psd_fields #(.NUM_STATES(5'h10)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .descriptor_o(descriptor_o), .ranks_valid_o(ranks_valid_o));
   initial forever #2 clk_i = ~clk_i;
   function automatic logic ranks_ok(input logic [127:0] d);
      return d[100:96] < 5'h10 && d[108:104] < 5'h10 && d[116:112] < 5'h10 && d[124:120] < 5'h10;
   endfunction
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (bad_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(descriptor_o, '0);
      void'($urandom(32'h2dde));
      // Corner ranks 15 and 16 sit either side of the default state count
      for (int i = 0; i < 40; i++) begin
         w = {$urandom, $urandom, $urandom, $urandom};
         if (i == 0) w = '1;
         if (i == 1) w[127:96] = 32'h0f0f0f0f;
         if (i == 2) w[127:96] = 32'h10101010;
         for (int k = 0; k < 4; k++) u_host.xfer(1'b1, 3'(k), w[32*k+:32], q);
         chk(descriptor_o, w & KEEP);
         chk(128'(ranks_valid_o), 128'(ranks_ok(w)));
         // Indices 4 to 7 take no write, so the descriptor must not move
         u_host.xfer(1'b1, 3'(4 + $urandom_range(3)), $urandom, q);
         chk(descriptor_o, w & KEEP);
         u_host.xfer(1'b0, 3'h4, 32'h0, q);
         chk(128'(q), 128'h10);
         u_host.xfer(1'b0, 3'h5, 32'h0, q);
         chk(128'(q), 128'(ranks_ok(w)));
         for (int k = 0; k < 4; k++) begin
            u_host.xfer(1'b0, 3'(k), $urandom, q);
            chk(128'(q), 128'(w[32*k+:32] & KEEP[32*k+:32]));
         end
      end
      // Reset in mid-run clears every field and restores the rank flag
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(descriptor_o, '0);
      chk(128'(ranks_valid_o), 128'h1);
      u_host.xfer(1'b0, 3'h3, 32'h0, q);
      chk(128'(q), '0);
      u_host.xfer(1'b0, 3'h6, 32'h0, q);
      chk(128'(q), '0);
      stop_test();
   end
endmodule
bind psd_fields psd_fields_properties #(.NUM_STATES(NUM_STATES)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i),
   .rd_i(rd_i), .ranks_valid_o(ranks_valid_o), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
   .descriptor_o(descriptor_o));
